/* File: card_socket_pkg.sv */
// Function
// - Second battery detect low, first high means weak battery, replace it.
// - First battery detect low means battery dead and card data lost.
// - Card audio on battery detect 2 used only in I/O interface mode.
// - Audio inputs of both slots are combined onto one output.
// - Both card detect lines low means a card is present.
// - Even byte enable selects even bytes, odd byte enable odd bytes.
// - I/O read strobe asserted during host I/O read cycles.
// - I/O write strobe driven low during host I/O write cycles.
// - I/O write strobe acts as DMA read strobe, memory to card.
// - Output enable driven low during host memory read cycles.
// - Output enable signals terminal count during DMA write to card.
// - Attribute select acts as DMA acknowledge during DMA operations.
package card_socket_pkg;
  // ****************************************
  // Slots and synchroniser
  // ****************************************
  localparam int NUM_SLOTS = 2;
  localparam int SYNC_STAGES = 3;
  localparam logic SYNC_RESET_VAL = 1'b1;
  localparam logic STROBE_IDLE = 1'b1;

  // ****************************************
  // Cycle and battery encodings
  // ****************************************
  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_MEM_READ,
    CYC_MEM_WRITE,
    CYC_IO_READ,
    CYC_IO_WRITE,
    CYC_DMA_TO_CARD,
    CYC_DMA_FROM_CARD
  } cycle_kind_t;

  typedef enum logic [1:0] {
    BATT_GOOD,
    BATT_WEAK,
    BATT_DEAD
  } batt_state_t;
endpackage : card_socket_pkg

/* File: in_sync.sv */
`timescale 1ns/1ps
module in_sync
  import card_socket_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out
);
  logic [SYNC_STAGES-1:0] stage_r;
  logic [SYNC_STAGES-1:0] stage_nxt;
  logic lvl_r;
  logic lvl_nxt;

  // ****************************************
  // Three stages, change counts once two agree
  // ****************************************
  always_comb begin
    stage_nxt = {stage_r[SYNC_STAGES-2:0], async_in};
    lvl_nxt = lvl_r;
    // Last two must agree, so one-sample glitches never reach the level
    if (stage_r[SYNC_STAGES-2] == stage_r[SYNC_STAGES-1]) begin
      lvl_nxt = stage_r[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      stage_r <= {SYNC_STAGES{SYNC_RESET_VAL}};
      lvl_r <= SYNC_RESET_VAL;
    end else begin
      stage_r <= stage_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule : in_sync

/* File: card_socket_ctrl.sv */
`timescale 1ns/1ps
module card_socket_ctrl
  import card_socket_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Host side, per slot
  input wire cycle_kind_t cycle_kind_in [NUM_SLOTS],
  input wire logic byte_addr0_in [NUM_SLOTS],
  input wire logic wide_access_in [NUM_SLOTS],
  input wire logic dma_last_in [NUM_SLOTS],
  input wire logic io_mode_in [NUM_SLOTS],
  input wire logic dma_mode_in [NUM_SLOTS],
  // Card pins, per slot
  input wire logic battery_detect_1_in [NUM_SLOTS],
  input wire logic battery_detect_2_in [NUM_SLOTS],
  input wire logic card_present_1_n_in [NUM_SLOTS],
  input wire logic card_present_2_n_in [NUM_SLOTS],
  input wire logic input_acknowledge_n_in [NUM_SLOTS],
  output logic even_byte_enable_n_out [NUM_SLOTS],
  output logic odd_byte_enable_n_out [NUM_SLOTS],
  output logic io_read_strobe_n_out [NUM_SLOTS],
  output logic io_write_strobe_n_out [NUM_SLOTS],
  output logic output_enable_n_out [NUM_SLOTS],
  output logic attr_select_n_out [NUM_SLOTS],
  // Status to host, per slot, plus the combined audio of both slots
  output logic card_inserted_out [NUM_SLOTS],
  output batt_state_t batt_state_out [NUM_SLOTS],
  output logic card_status_change_out [NUM_SLOTS],
  output logic ring_indicate_out [NUM_SLOTS],
  output logic io_read_ack_out [NUM_SLOTS],
  output logic dma_request_out [NUM_SLOTS],
  output logic combined_audio_out
);
  logic batt1_sync [NUM_SLOTS];
  logic batt2_sync [NUM_SLOTS];
  logic detect1_sync [NUM_SLOTS];
  logic detect2_sync [NUM_SLOTS];
  logic ack_sync [NUM_SLOTS];

  logic ce_even_r [NUM_SLOTS];
  logic ce_odd_r [NUM_SLOTS];
  logic rd_strobe_r [NUM_SLOTS];
  logic wr_strobe_r [NUM_SLOTS];
  logic oe_r [NUM_SLOTS];
  logic reg_r [NUM_SLOTS];
  logic ce_even_nxt [NUM_SLOTS];
  logic ce_odd_nxt [NUM_SLOTS];
  logic rd_strobe_nxt [NUM_SLOTS];
  logic wr_strobe_nxt [NUM_SLOTS];
  logic oe_nxt [NUM_SLOTS];
  logic reg_nxt [NUM_SLOTS];

  logic present_r [NUM_SLOTS];
  batt_state_t batt_r [NUM_SLOTS];
  logic status_chg_r [NUM_SLOTS];
  logic ring_r [NUM_SLOTS];
  logic ack_r [NUM_SLOTS];
  logic dreq_r [NUM_SLOTS];
  logic present_nxt [NUM_SLOTS];
  batt_state_t batt_nxt [NUM_SLOTS];
  logic status_chg_nxt [NUM_SLOTS];
  logic ring_nxt [NUM_SLOTS];
  logic ack_nxt [NUM_SLOTS];
  logic dreq_nxt [NUM_SLOTS];

  logic audio_r;
  logic audio_nxt;

  // ****************************************
  // Input synchronisers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_sync
      in_sync u_batt1 (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .async_in(battery_detect_1_in[g]), .level_out(batt1_sync[g]));
      in_sync u_batt2 (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .async_in(battery_detect_2_in[g]), .level_out(batt2_sync[g]));
      in_sync u_detect1 (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .async_in(card_present_1_n_in[g]), .level_out(detect1_sync[g]));
      in_sync u_detect2 (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .async_in(card_present_2_n_in[g]), .level_out(detect2_sync[g]));
      in_sync u_ack (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .async_in(input_acknowledge_n_in[g]), .level_out(ack_sync[g]));
    end
  endgenerate

  // ****************************************
  // Card strobes
  // ****************************************
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      ce_even_nxt[i] = STROBE_IDLE;
      ce_odd_nxt[i] = STROBE_IDLE;
      rd_strobe_nxt[i] = STROBE_IDLE;
      wr_strobe_nxt[i] = STROBE_IDLE;
      oe_nxt[i] = STROBE_IDLE;
      reg_nxt[i] = STROBE_IDLE;
      // Strobes only toward an inserted card
      if (present_r[i] && cycle_kind_in[i] != CYC_IDLE) begin
        // Wide access enables both lanes
        ce_even_nxt[i] = !(wide_access_in[i] || !byte_addr0_in[i]);
        ce_odd_nxt[i] = !(wide_access_in[i] || byte_addr0_in[i]);
        case (cycle_kind_in[i])
          CYC_MEM_READ: begin
            oe_nxt[i] = 1'b0;
          end
          CYC_IO_READ: begin
            rd_strobe_nxt[i] = 1'b0;
          end
          CYC_IO_WRITE: begin
            wr_strobe_nxt[i] = 1'b0;
          end
          CYC_DMA_TO_CARD: begin
            wr_strobe_nxt[i] = 1'b0;
            reg_nxt[i] = 1'b0;
            oe_nxt[i] = !dma_last_in[i];
          end
          CYC_DMA_FROM_CARD: begin
            rd_strobe_nxt[i] = 1'b0;
            reg_nxt[i] = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (rst_in) begin
        ce_even_r[i] <= STROBE_IDLE;
        ce_odd_r[i] <= STROBE_IDLE;
        rd_strobe_r[i] <= STROBE_IDLE;
        wr_strobe_r[i] <= STROBE_IDLE;
        oe_r[i] <= STROBE_IDLE;
        reg_r[i] <= STROBE_IDLE;
      end else begin
        ce_even_r[i] <= ce_even_nxt[i];
        ce_odd_r[i] <= ce_odd_nxt[i];
        rd_strobe_r[i] <= rd_strobe_nxt[i];
        wr_strobe_r[i] <= wr_strobe_nxt[i];
        oe_r[i] <= oe_nxt[i];
        reg_r[i] <= reg_nxt[i];
      end
    end
  end

  // ****************************************
  // Card status decode
  // ****************************************
  always_comb begin
    audio_nxt = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      present_nxt[i] = !detect1_sync[i] && !detect2_sync[i];
      batt_nxt[i] = BATT_GOOD;
      status_chg_nxt[i] = 1'b0;
      ring_nxt[i] = 1'b0;
      dreq_nxt[i] = 1'b0;
      ack_nxt[i] = 1'b0;
      if (present_nxt[i]) begin
        if (io_mode_in[i]) begin
          // Pin 1 carries status change or ring, active low
          status_chg_nxt[i] = !batt1_sync[i];
          ring_nxt[i] = !batt1_sync[i];
          if (dma_mode_in[i]) begin
            // Audio unavailable while pin 2 is the DMA request
            dreq_nxt[i] = !batt2_sync[i] || !ack_sync[i];
          end else begin
            audio_nxt = audio_nxt ^ batt2_sync[i];
            ack_nxt[i] = !ack_sync[i];
          end
        end else if (!batt1_sync[i]) begin
          batt_nxt[i] = BATT_DEAD;
        end else if (!batt2_sync[i]) begin
          batt_nxt[i] = BATT_WEAK;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      audio_r <= 1'b0;
    end else begin
      audio_r <= audio_nxt;
    end
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (rst_in) begin
        present_r[i] <= 1'b0;
        batt_r[i] <= BATT_GOOD;
        status_chg_r[i] <= 1'b0;
        ring_r[i] <= 1'b0;
        ack_r[i] <= 1'b0;
        dreq_r[i] <= 1'b0;
      end else begin
        present_r[i] <= present_nxt[i];
        batt_r[i] <= batt_nxt[i];
        status_chg_r[i] <= status_chg_nxt[i];
        ring_r[i] <= ring_nxt[i];
        ack_r[i] <= ack_nxt[i];
        dreq_r[i] <= dreq_nxt[i];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign even_byte_enable_n_out = ce_even_r;
  assign odd_byte_enable_n_out = ce_odd_r;
  assign io_read_strobe_n_out = rd_strobe_r;
  assign io_write_strobe_n_out = wr_strobe_r;
  assign output_enable_n_out = oe_r;
  assign attr_select_n_out = reg_r;
  assign card_inserted_out = present_r;
  assign batt_state_out = batt_r;
  assign card_status_change_out = status_chg_r;
  assign ring_indicate_out = ring_r;
  assign io_read_ack_out = ack_r;
  assign dma_request_out = dreq_r;
  assign combined_audio_out = audio_r;
endmodule : card_socket_ctrl

/* File: card_socket_checker.sv */
`timescale 1ns/1ps
module card_socket_checker
  import card_socket_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire cycle_kind_t cycle_kind_in [NUM_SLOTS],
  input wire logic byte_addr0_in [NUM_SLOTS],
  input wire logic wide_access_in [NUM_SLOTS],
  input wire logic dma_last_in [NUM_SLOTS],
  input wire logic card_present_1_n_in [NUM_SLOTS],
  input wire logic card_present_2_n_in [NUM_SLOTS],
  input wire logic even_byte_enable_n_out [NUM_SLOTS],
  input wire logic odd_byte_enable_n_out [NUM_SLOTS],
  input wire logic io_read_strobe_n_out [NUM_SLOTS],
  input wire logic io_write_strobe_n_out [NUM_SLOTS],
  input wire logic output_enable_n_out [NUM_SLOTS],
  input wire logic attr_select_n_out [NUM_SLOTS],
  input wire logic card_inserted_out [NUM_SLOTS]
);
  // ****************************************
  // Slot A strobes, lanes and detect
  // ****************************************
  cycle_kind_t k;
  logic ok;
  assign k = cycle_kind_in[0];
  assign ok = card_inserted_out[0];
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_rd; k == CYC_IO_READ && ok |=> !io_read_strobe_n_out[0]; endproperty
  a_rd: assert property (p_rd) else $error("io read strobe missing");
  property p_wr; k == CYC_IO_WRITE && ok |=> !io_write_strobe_n_out[0]; endproperty
  a_wr: assert property (p_wr) else $error("io write strobe missing");
  property p_oe; k == CYC_MEM_READ && ok |=> !output_enable_n_out[0]; endproperty
  a_oe: assert property (p_oe) else $error("output enable missing");
  property p_dto;
    k == CYC_DMA_TO_CARD && ok |=> !io_write_strobe_n_out[0] && !attr_select_n_out[0];
  endproperty
  a_dto: assert property (p_dto) else $error("dma to card strobes wrong");
  property p_last; k == CYC_DMA_TO_CARD && ok && dma_last_in[0] |=> !output_enable_n_out[0];
  endproperty
  a_last: assert property (p_last) else $error("terminal count missing");
  property p_dfr;
    k == CYC_DMA_FROM_CARD && ok |=> !io_read_strobe_n_out[0] && !attr_select_n_out[0];
  endproperty
  a_dfr: assert property (p_dfr) else $error("dma from card strobes wrong");
  property p_lane;
    k inside {CYC_MEM_READ, CYC_MEM_WRITE, CYC_IO_READ, CYC_IO_WRITE} && ok
      && !wide_access_in[0] |=> even_byte_enable_n_out[0] == $past(byte_addr0_in[0])
      && odd_byte_enable_n_out[0] != $past(byte_addr0_in[0]);
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane wrong");
  // Seven samples cover sync, level check and status register
  property p_ins; (!card_present_1_n_in[0] && !card_present_2_n_in[0]) [*7] |-> ok;
  endproperty
  a_ins: assert property (p_ins) else $error("card not seen");
  property p_idle;
    !ok |=> io_read_strobe_n_out[0] && io_write_strobe_n_out[0] && output_enable_n_out[0];
  endproperty
  a_idle: assert property (p_idle) else $error("strobe with empty slot");
endmodule : card_socket_checker

bind card_socket_ctrl card_socket_checker u_card_socket_checker (.sys_clk_in, .rst_in,
  .cycle_kind_in, .byte_addr0_in, .wide_access_in, .dma_last_in, .card_present_1_n_in,
  .card_present_2_n_in, .even_byte_enable_n_out, .odd_byte_enable_n_out,
  .io_read_strobe_n_out, .io_write_strobe_n_out, .output_enable_n_out,
  .attr_select_n_out, .card_inserted_out);

/* File: card_model.sv */
`timescale 1ns/1ps
module card_model
  import card_socket_pkg::*;
(
  input wire logic insert_in [NUM_SLOTS],
  input wire logic half_in [NUM_SLOTS],
  input wire logic batt1_in [NUM_SLOTS],
  input wire logic batt2_in [NUM_SLOTS],
  input wire logic ack_n_in [NUM_SLOTS],
  output logic batt1_out [NUM_SLOTS],
  output logic batt2_out [NUM_SLOTS],
  output logic detect1_n_out [NUM_SLOTS],
  output logic detect2_n_out [NUM_SLOTS],
  output logic ack_n_out [NUM_SLOTS]
);
  // ****************************************
  // Card pins, pulled up when slot empty
  // ****************************************
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      // Half inserted: only the first detect contact has closed
      detect1_n_out[i] = !insert_in[i];
      detect2_n_out[i] = !(insert_in[i] && !half_in[i]);
      batt1_out[i] = insert_in[i] ? batt1_in[i] : 1'b1;
      batt2_out[i] = insert_in[i] ? batt2_in[i] : 1'b1;
      ack_n_out[i] = insert_in[i] ? ack_n_in[i] : 1'b1;
    end
  end
endmodule : card_model

/* File: card_socket_ctrl_test.sv */
`timescale 1ns/1ps
module card_socket_ctrl_test
  import card_socket_pkg::*;
;
  // ****************************************
  // Stimulus, design and card
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  cycle_kind_t kind [2] = '{CYC_IDLE, CYC_IDLE};
  logic a0 [2] = '{1'b0, 1'b0}, wide [2] = '{1'b0, 1'b0}, last [2] = '{1'b0, 1'b0};
  logic iom [2] = '{1'b0, 1'b0}, dmam [2] = '{1'b0, 1'b0}, ins [2] = '{1'b1, 1'b1};
  logic half [2] = '{1'b0, 1'b0}, bv1 [2] = '{1'b1, 1'b1}, bv2 [2] = '{1'b1, 1'b1};
  logic ackn [2] = '{1'b1, 1'b1};
  logic p1 [2], p2 [2], d1n [2], d2n [2], akn [2], e_n [2], o_n [2], rd_n [2], wr_n [2];
  logic oe_n [2], at_n [2], insd [2], sc [2], ring [2], iack [2], dreq [2], aud;
  batt_state_t batt [2];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  card_socket_ctrl u_card_socket_ctrl (.sys_clk_in(clk), .rst_in(rst), .cycle_kind_in(kind),
    .byte_addr0_in(a0), .wide_access_in(wide), .dma_last_in(last), .io_mode_in(iom),
    .dma_mode_in(dmam), .battery_detect_1_in(p1), .battery_detect_2_in(p2),
    .card_present_1_n_in(d1n), .card_present_2_n_in(d2n), .input_acknowledge_n_in(akn),
    .even_byte_enable_n_out(e_n), .odd_byte_enable_n_out(o_n), .io_read_strobe_n_out(rd_n),
    .io_write_strobe_n_out(wr_n), .output_enable_n_out(oe_n), .attr_select_n_out(at_n),
    .card_inserted_out(insd), .batt_state_out(batt), .card_status_change_out(sc),
    .ring_indicate_out(ring), .io_read_ack_out(iack), .dma_request_out(dreq),
    .combined_audio_out(aud));
  card_model u_card_model (.insert_in(ins), .half_in(half), .batt1_in(bv1), .batt2_in(bv2),
    .ack_n_in(ackn), .batt1_out(p1), .batt2_out(p2), .detect1_n_out(d1n),
    .detect2_n_out(d2n), .ack_n_out(akn));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: output mismatch", $time);
    end
  endtask : chk
  // Status paths need five edges to pass the synchronisers and status register
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic t_strobes;
    cycle_kind_t k;
    for (int i = 1; i < 7; i++) begin
      k = cycle_kind_t'(i);
      @(posedge clk);
      kind[0] <= k;
      a0[0] <= i[0];
      last[0] <= i[0];
      wide[0] <= (i == 4);
      tick(1);
      chk(rd_n[0], !(k == CYC_IO_READ || k == CYC_DMA_FROM_CARD));
      chk(wr_n[0], !(k == CYC_IO_WRITE || k == CYC_DMA_TO_CARD));
      chk(oe_n[0], !(k == CYC_MEM_READ || k == CYC_DMA_TO_CARD));
      chk(at_n[0], !(i > 4));
      if (i < 5) begin
        chk(e_n[0], i == 1 || i == 3);
        chk(o_n[0], i == 2);
      end
    end
    @(posedge clk);
    kind[0] <= CYC_DMA_TO_CARD;
    last[0] <= 1'b0;
    tick(1);
    chk(oe_n[0], 1'b1);
  endtask : t_strobes
  task automatic t_nocard;
    @(posedge clk);
    ins[0] <= 1'b0;
    kind[0] <= CYC_IO_READ;
    tick(8);
    chk(insd[0], 1'b0);
    chk(rd_n[0], 1'b1);
    @(posedge clk);
    ins[0] <= 1'b1;
    kind[0] <= CYC_IDLE;
    tick(8);
    chk(insd[0], 1'b1);
    @(posedge clk);
    half[0] <= 1'b1;
    tick(8);
    chk(insd[0], 1'b0);
    @(posedge clk);
    half[0] <= 1'b0;
    tick(8);
    chk(insd[0], 1'b1);
  endtask : t_nocard
  task automatic t_batt;
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      bv1[1] <= !j[1];
      bv2[1] <= !j[0];
      tick(8);
      chk(batt[1] === (j[1] ? BATT_DEAD : j[0] ? BATT_WEAK : BATT_GOOD), 1'b1);
    end
  endtask : t_batt
  task automatic t_io;
    @(posedge clk);
    iom <= '{1'b1, 1'b1};
    bv1[0] <= 1'b0;
    ackn[0] <= 1'b0;
    tick(8);
    chk(sc[0], 1'b1);
    chk(ring[0], 1'b1);
    chk(iack[0], 1'b1);
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      bv2 <= '{j[0], j[1]};
      tick(8);
      chk(aud, j[0] ^ j[1]);
    end
    @(posedge clk);
    dmam[0] <= 1'b1;
    ackn[0] <= 1'b1;
    bv2[0] <= 1'b0;
    tick(8);
    chk(dreq[0], 1'b1);
    chk(aud, 1'b1);
    @(posedge clk);
    bv2[0] <= 1'b1;
    ackn[0] <= 1'b0;
    tick(8);
    chk(dreq[0], 1'b1);
    chk(iack[0], 1'b0);
    @(posedge clk);
    ackn[0] <= 1'b1;
    tick(8);
    chk(dreq[0], 1'b0);
  endtask : t_io
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(8);
    chk(insd[0], 1'b1);
    chk(insd[1], 1'b1);
    t_strobes();
    t_nocard();
    t_batt();
    t_io();
    test_done();
  end
endmodule : card_socket_ctrl_test
